// ---- rtl/pio_pkg.sv ----
/*
  Package for the dual I/O port block: register offsets, field positions,
  reset values, bus and pin carrier structs and the handshake state codes.
  Assumes a classic Wishbone master with 32-bit data on the same clock.
*/
package pio_pkg;

  // Word-aligned byte offsets of the registers
  localparam logic [7:0] PIO_OFF_PCFG = 8'h00;
  localparam logic [7:0] PIO_OFF_FMODE = 8'h04;
  localparam logic [7:0] PIO_OFF_BDIR = 8'h08;
  localparam logic [7:0] PIO_OFF_BOUT = 8'h0c;
  localparam logic [7:0] PIO_OFF_BIN = 8'h10;
  localparam logic [7:0] PIO_OFF_FOUT = 8'h14;
  localparam logic [7:0] PIO_OFF_FIN = 8'h18;
  localparam logic [7:0] PIO_OFF_IRQ = 8'h1c;

  // port_config_reg fields
  localparam int PIO_PCFG_CMP_OUT = 0;
  localparam int PIO_PCFG_OPEN_DRAIN = 1;
  localparam int PIO_PCFG_LOW_EMI = 2;
  // fixed_port_mode_reg fields
  localparam int PIO_FMODE_HSK = 0;
  localparam int PIO_FMODE_ANALOG = 1;
  localparam int PIO_FMODE_EDGE1 = 2;
  localparam int PIO_FMODE_EDGE2 = 4;
  localparam int PIO_FMODE_TMR_OUT = 6;

  // Edge selection codes for lines 1 and 2
  localparam logic [1:0] PIO_EDGE_FALL = 2'h0;
  localparam logic [1:0] PIO_EDGE_RISE = 2'h1;
  localparam logic [1:0] PIO_EDGE_BOTH = 2'h2;

  // Reset values: all bidirectional lines input, everything off
  localparam logic [7:0] PIO_PCFG_RST = 8'h00;
  localparam logic [7:0] PIO_FMODE_RST = 8'h00;
  localparam logic [7:0] PIO_BDIR_RST = 8'hff;
  localparam logic [7:0] PIO_BYTE_RST = 8'h00;
  // Interrupt lines idle high, so the edge history starts there
  localparam logic [3:0] PIO_FIN_IDLE = 4'hf;

  // Comparator settle guard after an analog mode change (two short instruction times)
  localparam int PIO_CMP_SETTLE_NS = 480;
  localparam int PIO_CLK_NS = 40;
  localparam int PIO_CMP_SETTLE_CYC = (PIO_CMP_SETTLE_NS + PIO_CLK_NS - 1) / PIO_CLK_NS;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pio_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pio_wb_rsp_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic low_emi;
  } pio_bpins_t;

  typedef struct packed {
    logic [7:4] o;
    logic low_emi;
  } pio_fpins_t;

  typedef enum logic [1:0] {
    PIO_HS_IDLE = 2'b00,
    PIO_HS_REQ = 2'b01,
    PIO_HS_WAIT = 2'b10
  } pio_hs_t;

endpackage

// ---- rtl/pio_port.sv ----
/*
  Bidirectional 8-line port plus fixed-direction 8-line port with edge
  interrupt inputs, two comparators, timer routing and byte handshake.
  Assumes pins arrive asynchronously; comparator results and the external
  timer output come in as plain levels from neighbouring analog and timer logic.
*/
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Function
// RL1: Eight bidirectional lines, Schmitt-buffered inputs
// RL2: Per-line direction set independently
// RL3: One global push-pull or open-drain select
// RL4: One global low-emission drive mode
// RL5: Handshake uses fixed line 1 in, 6 out
// RL6: Handshake direction follows line 7 direction
// RL7: Lines 0-3 inputs, 4-7 push-pull outputs
// RL8: Mode bit 1 enables comparators
// RL9: Config bit 0 drives comparators onto 4, 7
// RL10: Lines 0 and 3 interrupt on falling edge
// RL11: Lines 1, 2 select fall, rise, both
// RL12: Timer input line 1, output line 6
// RL13: Fixed port carries other ports' handshake
// RL14: Software waits before reading comparator
// RL15: Software masks interrupts around mode change
// RL16: Software clears low requests after enable
// RL17: Config register at offset zero
// RL18: Synchronised edge sets request once
// RL19: Interlocked request/acknowledge per byte
module pio_port
  import pio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pio_pkg::pio_wb_req_t wb_i,
  output pio_pkg::pio_wb_rsp_t wb_o,
  input wire logic [7:0] bport_i,
  output pio_pkg::pio_bpins_t bport_o,
  input wire logic [3:0] fport_i,
  output pio_pkg::pio_fpins_t fport_o,
  input wire logic [1:0] cmp_i,
  input wire logic [1:0] xhs_out_i,
  input wire logic tmr_out_i,
  output logic [3:0] irq_o,
  output logic tmr_in_o,
  output logic [1:0] xhs_in_o
);
  import pio_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] pcfg;
    logic [7:0] fmode;
    logic [7:0] bdir;
    logic [7:0] bout;
    logic [7:0] blatch;
    logic [7:4] fout;
    logic [3:0] irq;
    logic [7:0] bs1;
    logic [7:0] bs2;
    logic [3:0] fs1;
    logic [3:0] fs2;
    logic [3:0] fprev;
    pio_hs_t hs;
    logic hs_out;
    logic [4:0] settle;
    pio_bpins_t bp;
    pio_fpins_t fp;
    logic tmr_in;
    logic [1:0] xhs_in;
  } pio_state_t;

  pio_state_t s;
  pio_state_t next_s;
  logic [3:0] fall;
  logic [3:0] rise;
  logic [3:0] hit;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic hs_ack;
  logic hs_in_dir;
  logic [7:0] drive;

  // Edges are seen only on the second sync stage, never on the first
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_edge
      assign fall[g] = s.fprev[g] & ~s.fs2[g];
      assign rise[g] = ~s.fprev[g] & s.fs2[g];
    end
  endgenerate

  // RL10 RL11
  always_comb
  begin
    hit[0] = fall[0];
    hit[3] = fall[3];
    unique case (s.fmode[PIO_FMODE_EDGE1 +: 2])
      PIO_EDGE_RISE: hit[1] = rise[1];
      PIO_EDGE_BOTH: hit[1] = rise[1] | fall[1];
      default: hit[1] = fall[1];
    endcase
    unique case (s.fmode[PIO_FMODE_EDGE2 +: 2])
      PIO_EDGE_RISE: hit[2] = rise[2];
      PIO_EDGE_BOTH: hit[2] = rise[2] | fall[2];
      default: hit[2] = fall[2];
    endcase
  end

  assign wr = wb_i.cyc & wb_i.stb & wb_i.we & ~s.ack & wb_i.sel[0];
  assign rd = wb_i.cyc & wb_i.stb & ~s.ack;
  assign wbyte = wb_i.dat[7:0];
  assign hs_ack = s.fs2[1]; // RL5
  assign hs_in_dir = s.bdir[7]; // RL6

  always_comb
  begin
    next_s = s;
    next_s.ack = wb_i.cyc & wb_i.stb & ~s.ack;
    next_s.bs1 = bport_i;
    next_s.bs2 = s.bs1;
    next_s.fs1 = fport_i;
    next_s.fs2 = s.fs1;
    next_s.fprev = s.fs2;
    if (s.settle != 5'h00)
    begin
      next_s.settle = s.settle - 5'h01;
    end
    // Set wins over a same-cycle clear below
    next_s.irq = s.irq | hit; // RL18
    if (wr)
    begin
      unique case (wb_i.adr)
        PIO_OFF_PCFG: next_s.pcfg = wbyte; // RL17
        PIO_OFF_FMODE:
        begin
          next_s.fmode = wbyte;
          if (wbyte[PIO_FMODE_ANALOG] != s.fmode[PIO_FMODE_ANALOG])
          begin
            next_s.settle = 5'(PIO_CMP_SETTLE_CYC);
          end
        end
        PIO_OFF_BDIR: next_s.bdir = wbyte; // RL2
        PIO_OFF_BOUT:
        begin
          next_s.bout = wbyte;
          // Writing output data starts a transfer when line 7 is output
          if (s.fmode[PIO_FMODE_HSK] && !hs_in_dir && s.hs == PIO_HS_IDLE)
          begin
            next_s.hs = PIO_HS_REQ;
          end
        end
        PIO_OFF_FOUT: next_s.fout = wbyte[7:4];
        PIO_OFF_IRQ: next_s.irq = (s.irq & ~wbyte[3:0]) | hit;
        default: ;
      endcase
    end
    // RL19
    unique case (s.hs)
      PIO_HS_IDLE:
      begin
        next_s.hs_out = 1'b0;
        if (s.fmode[PIO_FMODE_HSK] && hs_in_dir && !hs_ack)
        begin
          next_s.blatch = s.bs2; // RL5
          next_s.hs_out = 1'b1;
          next_s.hs = PIO_HS_WAIT;
        end
      end
      PIO_HS_REQ:
      begin
        next_s.hs_out = 1'b1;
        if (!hs_ack)
        begin
          next_s.hs = PIO_HS_WAIT;
        end
      end
      PIO_HS_WAIT:
      begin
        if (hs_ack)
        begin
          next_s.hs_out = 1'b0;
          next_s.hs = PIO_HS_IDLE;
        end
      end
      default: next_s.hs = PIO_HS_IDLE;
    endcase
    if (!s.fmode[PIO_FMODE_HSK])
    begin
      next_s.hs = PIO_HS_IDLE;
      next_s.hs_out = 1'b0;
      next_s.blatch = s.bs2; // RL1
    end
    unique case (wb_i.adr)
      PIO_OFF_PCFG: next_s.rdat = {24'h000000, s.pcfg};
      PIO_OFF_FMODE: next_s.rdat = {24'h000000, s.fmode};
      PIO_OFF_BDIR: next_s.rdat = {24'h000000, s.bdir};
      PIO_OFF_BOUT: next_s.rdat = {24'h000000, s.bout};
      PIO_OFF_BIN: next_s.rdat = {24'h000000, s.blatch};
      PIO_OFF_FOUT: next_s.rdat = {24'h000000, s.fout, 4'h0};
      PIO_OFF_FIN: next_s.rdat = {23'h000000, s.settle == 5'h00, 4'h0, s.fs2};
      PIO_OFF_IRQ: next_s.rdat = {28'h0000000, s.irq};
      default: next_s.rdat = 32'h00000000;
    endcase
    if (!rd)
    begin
      next_s.rdat = 32'h00000000;
    end
    // Bidirectional pin drive
    drive = s.bout;
    for (int i = 0; i < 8; i++)
    begin
      next_s.bp.o[i] = s.pcfg[PIO_PCFG_OPEN_DRAIN] ? 1'b0 : drive[i]; // RL3
      next_s.bp.oe[i] = ~s.bdir[i] & (~s.pcfg[PIO_PCFG_OPEN_DRAIN] | ~drive[i]); // RL2
    end
    next_s.bp.low_emi = s.pcfg[PIO_PCFG_LOW_EMI]; // RL4
    next_s.fp.low_emi = s.pcfg[PIO_PCFG_LOW_EMI]; // RL4
    // RL7
    next_s.fp.o[5] = s.fout[5];
    next_s.fp.o[4] = s.fout[4];
    next_s.fp.o[7] = s.fout[7];
    next_s.fp.o[6] = s.fout[6];
    if (s.fmode[PIO_FMODE_ANALOG] && s.pcfg[PIO_PCFG_CMP_OUT])
    begin
      next_s.fp.o[4] = cmp_i[0]; // RL9
      next_s.fp.o[7] = cmp_i[1]; // RL9
    end
    if (s.fmode[PIO_FMODE_HSK])
    begin
      // Strobe leaves with the state change, not one cycle after it
      next_s.fp.o[6] = next_s.hs_out; // RL5
    end
    else if (s.fmode[PIO_FMODE_TMR_OUT])
    begin
      next_s.fp.o[6] = tmr_out_i; // RL12
    end
    else if (xhs_out_i[0])
    begin
      next_s.fp.o[5] = 1'b1; // RL13
    end
    next_s.tmr_in = s.fs2[1]; // RL12
    // Analog mode forces the cross-port handshake inputs to zero; FIN and the edge requests still see the lines
    next_s.xhs_in = s.fmode[PIO_FMODE_ANALOG] ? 2'h0 : {s.fs2[2], s.fs2[0]}; // RL8 RL13
    if (xhs_out_i[1] && !s.fmode[PIO_FMODE_ANALOG])
    begin
      next_s.fp.o[5] = 1'b0; // RL13
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.pcfg <= PIO_PCFG_RST;
      s.fmode <= PIO_FMODE_RST;
      s.bdir <= PIO_BDIR_RST;
      s.bout <= PIO_BYTE_RST;
      s.hs <= PIO_HS_IDLE;
      // Avoid a false edge on the first cycles after reset
      s.fs1 <= PIO_FIN_IDLE;
      s.fs2 <= PIO_FIN_IDLE;
      s.fprev <= PIO_FIN_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_o.ack = s.ack;
  assign wb_o.dat = s.rdat;
  assign bport_o = s.bp;
  assign fport_o = s.fp;
  assign irq_o = s.irq;
  assign tmr_in_o = s.tmr_in;
  assign xhs_in_o = s.xhs_in;

  chk_fall_sets_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    fall[0] |=> s.irq[0]) else $error("line0 fall not latched"); // RL10
  chk_rise_no_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    rise[3] && !s.irq[3] && !fall[3] |=> !s.irq[3]) else $error("line3 rise set irq"); // RL10
  chk_rise_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    rise[1] && s.fmode[3:2] == PIO_EDGE_RISE |=> s.irq[1]) else $error("rise missed"); // RL11
  chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_o.ack |=> !wb_o.ack) else $error("ack held"); // RL17
  chk_dir_input: assert property (@(posedge clk_i) disable iff (rst_i)
    s.bdir[2] && $stable(s.bdir) |=> !bport_o.oe[2]) else $error("input driven"); // RL2
  chk_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    s.pcfg[PIO_PCFG_OPEN_DRAIN] |=> bport_o.o == 8'h00) else $error("od drives high"); // RL3
  chk_emi_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> fport_o.low_emi == $past(s.pcfg[PIO_PCFG_LOW_EMI])) else $error("emi"); // RL4
  sequence hs_start_s;
    s.hs == PIO_HS_REQ;
  endsequence
  chk_hs_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    hs_start_s |=> fport_o.o[6]) else $error("strobe missing"); // RL19
  chk_cmp_route: assert property (@(posedge clk_i) disable iff (rst_i)
    s.fmode[1] && s.pcfg[0] |=> fport_o.o[4] == $past(cmp_i[0])) else $error("cmp"); // RL9
  chk_fall_line3: assert property (@(posedge clk_i) disable iff (rst_i)
    fall[3] |=> s.irq[3]) else $error("line3 fall not latched"); // RL10
  chk_both_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    rise[2] && s.fmode[5:4] == PIO_EDGE_BOTH |=> s.irq[2]) else $error("both missed"); // RL11
  chk_fall_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    fall[2] && s.fmode[5:4] == PIO_EDGE_FALL |=> s.irq[2]) else $error("fall missed"); // RL11
  chk_irq_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    s.irq[0] && !(wr && wb_i.adr == PIO_OFF_IRQ) |=> s.irq[0]) else $error("irq lost"); // RL18
  chk_push_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.bdir[5] && !s.pcfg[PIO_PCFG_OPEN_DRAIN] |=> bport_o.oe[5]) else $error("no drive"); // RL2
  chk_bemi_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> bport_o.low_emi == $past(s.pcfg[PIO_PCFG_LOW_EMI])) else $error("bemi"); // RL4
  chk_tmr_route: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> tmr_in_o == $past(s.fs2[1])) else $error("timer input"); // RL12
  chk_fout_plain: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.fmode[1] |=> fport_o.o[7] == $past(s.fout[7])) else $error("line7 data"); // RL7
  chk_xhs_analog: assert property (@(posedge clk_i) disable iff (rst_i)
    s.fmode[PIO_FMODE_ANALOG] |=> xhs_in_o == 2'h0) else $error("analog leak"); // RL8
  chk_settle_load: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && wb_i.adr == PIO_OFF_FMODE && wbyte[1] != s.fmode[1]
    |=> s.settle == 5'(PIO_CMP_SETTLE_CYC)) else $error("settle guard"); // RL14
  // Strobe must stay up until the partner answers
  sequence hs_wait_s;
    s.hs == PIO_HS_WAIT && !hs_ack && s.fmode[PIO_FMODE_HSK] && !wr;
  endsequence
  chk_strobe_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    hs_wait_s |=> fport_o.o[6]) else $error("strobe dropped"); // RL19
  // Input transfer: sender pulls line 1 low, byte is captured
  sequence hs_in_s;
    s.fmode[PIO_FMODE_HSK] && s.bdir[7] && s.hs == PIO_HS_IDLE && !hs_ack && !wr;
  endsequence
  chk_in_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    hs_in_s |=> s.blatch == $past(s.bs2)) else $error("byte not latched"); // RL5 RL6
endmodule // pio_port

// ---- dv/pio_periph.sv ----
/*
  Peripheral model on the port pins: resolves the bidirectional lines
  and answers the byte handshake on fixed line 1.
  Assumes the bench's clock and its levels for undriven lines.
*/
`timescale 1ns/1ps
module pio_periph
  import pio_pkg::*;
(
  input wire logic clk_i,
  input wire pio_pkg::pio_bpins_t pins_i,
  input wire logic [7:0] ext_b_i,
  input wire logic [3:0] ext_f_i,
  input wire logic hs_en_i,
  input wire logic strobe_i,
  input wire logic [3:0] delay_i,
  output logic [7:0] bport_o,
  output logic [3:0] fport_o
);
  logic ack = 1'b1;
  int cnt = 0;
  // An enabled driver wins; a released line shows the outside level
  assign bport_o = (pins_i.oe & pins_i.o) | (~pins_i.oe & ext_b_i);
  assign fport_o = {ext_f_i[3:2], hs_en_i ? ack : ext_f_i[1], ext_f_i[0]};
  // Ack falls after the strobe and returns high after a delay
  always @(posedge clk_i)
  begin
    if (!strobe_i || !hs_en_i)
    begin
      ack <= 1'b1;
      cnt <= 0;
    end
    else
    begin
      cnt <= cnt + 1;
      ack <= !(cnt >= delay_i && cnt < 2 * delay_i);
    end
  end
endmodule // pio_periph

// ---- dv/testbench.sv ----
/*
  Self-checking bench for the dual port block.
  Assumes pio_periph models the pins and a classic Wishbone master.
*/
`timescale 1ns/1ps
module testbench;
  import pio_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pio_wb_req_t wb_i = '0;
  pio_wb_rsp_t wb_o;
  pio_bpins_t bport_o;
  pio_fpins_t fport_o;
  logic [7:0] bport_i;
  logic [7:0] ext_b = 8'h00;
  logic [3:0] fport_i;
  logic [3:0] irq_o;
  logic [3:0] ext_f = 4'hf;
  logic [3:0] dly = 4'h1;
  logic [1:0] cmp_i = 2'h0;
  logic [1:0] xhs_out_i = 2'h2;
  logic [1:0] xhs_in_o;
  logic tmr_out_i = 1'b0;
  logic tmr_in_o;
  logic hs_en = 1'b0;
  logic [31:0] rd;
  int bad_count = 0;
  int checks_done = 0;

  pio_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .bport_i(bport_i), .bport_o(bport_o), .fport_i(fport_i), .fport_o(fport_o),
    .cmp_i(cmp_i), .xhs_out_i(xhs_out_i), .tmr_out_i(tmr_out_i), .irq_o(irq_o),
    .tmr_in_o(tmr_in_o), .xhs_in_o(xhs_in_o));
  pio_periph i_periph (.clk_i(clk_i), .pins_i(bport_o), .ext_b_i(ext_b),
    .ext_f_i(ext_f), .hs_en_i(hs_en), .strobe_i(fport_o.o[6]), .delay_i(dly),
    .bport_o(bport_i), .fport_o(fport_i));

  initial forever #20 clk_i = ~clk_i;

  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic stuck();
    bad_count++;
    end_of_test();
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Read data lands in rd; the bus stays idle for one cycle afterwards
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_i <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_o.ack !== 1'b1 && n < 20);
    rd = wb_o.dat;
    wb_i <= '0;
    @(posedge clk_i);
    if (n == 20)
      stuck();
  endtask

  // Longer than the pin to register and pin to request latency
  task automatic pause();
    repeat (6) @(posedge clk_i);
  endtask

  task automatic t_reset();
    wb(1'b0, PIO_OFF_PCFG, 32'h0);
    chk("pcfg", rd, {24'h0, PIO_PCFG_RST});
    wb(1'b0, PIO_OFF_BDIR, 32'h0);
    chk("bdir", rd, {24'h0, PIO_BDIR_RST});
    chk("oe", bport_o.oe, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask

  task automatic t_dir();
    ext_b <= 8'h3c;
    wb(1'b1, PIO_OFF_BDIR, 32'h0f);
    wb(1'b1, PIO_OFF_BOUT, 32'ha5);
    pause();
    chk("oe", bport_o.oe, 32'hf0);
    chk("out", bport_o.o[7:4], 32'ha);
    wb(1'b0, PIO_OFF_BIN, 32'h0);
    chk("bin", rd, 32'hac);
    wb(1'b1, PIO_OFF_PCFG, 32'h06);
    pause();
    chk("od_oe", bport_o.oe, 32'h50);
    chk("od_o", bport_o.o[7:4], 32'h0);
    chk("emi", {bport_o.low_emi, fport_o.low_emi}, 32'h3);
    wb(1'b1, PIO_OFF_PCFG, 32'h0);
  endtask

  task automatic t_fixed();
    wb(1'b1, PIO_OFF_FOUT, 32'h90);
    ext_f <= 4'h5;
    pause();
    chk("fout", {fport_o.o[7:6], fport_o.o[4]}, 32'h5);
    wb(1'b0, PIO_OFF_FIN, 32'h0);
    chk("fin", rd[3:0], 32'h5);
    chk("xhs_in", xhs_in_o, 32'h3);
    chk("line5_lo", fport_o.o[5], 32'h0);
    xhs_out_i <= 2'h1;
    pause();
    chk("line5_hi", fport_o.o[5], 32'h1);
    xhs_out_i <= 2'h2;
    cmp_i <= 2'h1;
    wb(1'b1, PIO_OFF_FMODE, 32'h02);
    wb(1'b1, PIO_OFF_PCFG, 32'h01);
    pause();
    pause();
    chk("cmp_a", {fport_o.o[7], fport_o.o[4]}, 32'h1);
    cmp_i <= 2'h2;
    pause();
    chk("cmp_b", {fport_o.o[7], fport_o.o[4]}, 32'h2);
    wb(1'b1, PIO_OFF_FMODE, 32'h0);
    wb(1'b1, PIO_OFF_PCFG, 32'h0);
    wb(1'b1, PIO_OFF_IRQ, 32'h0f);
  endtask

  task automatic t_irq();
    int c;
    ext_f <= 4'hf;
    pause();
    for (c = 0; c < 3; c++)
    begin
      wb(1'b1, PIO_OFF_FMODE, 32'(c * 20));
      wb(1'b1, PIO_OFF_IRQ, 32'h0f);
      chk("irq_clr", irq_o, 32'h0);
      ext_f <= 4'h0;
      pause();
      chk("irq_fall", irq_o, {1'b1, {2{c != 1}}, 1'b1});
      wb(1'b1, PIO_OFF_IRQ, 32'h0f);
      ext_f <= 4'hf;
      pause();
      chk("irq_rise", irq_o, {1'b0, {2{c != 0}}, 1'b0});
    end
    wb(1'b1, PIO_OFF_FMODE, 32'h0);
  endtask

  task automatic t_timer();
    wb(1'b1, PIO_OFF_FMODE, 32'h40);
    tmr_out_i <= 1'b1;
    ext_f <= 4'hd;
    pause();
    chk("tmr", {fport_o.o[6], tmr_in_o}, 32'h2);
    tmr_out_i <= 1'b0;
    ext_f <= 4'hf;
    pause();
    chk("tmr", {fport_o.o[6], tmr_in_o}, 32'h1);
    wb(1'b1, PIO_OFF_FMODE, 32'h0);
    wb(1'b1, PIO_OFF_IRQ, 32'h0f);
  endtask

  task automatic t_hs(input logic [3:0] d);
    int n;
    dly <= d;
    hs_en <= 1'b1;
    wb(1'b1, PIO_OFF_BDIR, 32'h00);
    wb(1'b1, PIO_OFF_FMODE, 32'h01);
    pause();
    chk("hs_idle", fport_o.o[6], 32'h0);
    wb(1'b1, PIO_OFF_BOUT, 32'h3c);
    n = 0;
    while (fport_i[1] !== 1'b0 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("hs_strobe", fport_o.o[6], 32'h1);
    chk("hs_data", {bport_o.oe, bport_o.o}, 32'hff3c);
    while (fport_o.o[6] !== 1'b0 && n < 80)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("hs_ack", fport_i[1], 32'h1);
    if (n >= 40)
      stuck();
    wb(1'b1, PIO_OFF_FMODE, 32'h0);
    hs_en <= 1'b0;
  endtask

  // Input transfer: line 7 input, sender drives line 1 itself
  task automatic t_hs_in();
    wb(1'b1, PIO_OFF_BDIR, 32'hff);
    ext_b <= 8'h5a;
    wb(1'b1, PIO_OFF_FMODE, 32'h01);
    ext_f <= 4'hd;
    pause();
    chk("hsi_strobe", fport_o.o[6], 32'h1);
    ext_b <= 8'h00;
    pause();
    wb(1'b0, PIO_OFF_BIN, 32'h0);
    chk("hsi_data", rd, 32'h5a);
    ext_f <= 4'hf;
    pause();
    chk("hsi_done", fport_o.o[6], 32'h0);
    wb(1'b1, PIO_OFF_FMODE, 32'h0);
    wb(1'b1, PIO_OFF_IRQ, 32'h0f);
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_dir();
    t_fixed();
    t_irq();
    t_timer();
    t_hs(4'h1);
    t_hs(4'h6);
    t_hs_in();
    end_of_test();
  end
endmodule // testbench
